/* hdl/synth_loader.sv */
// Controller end: AHB-Lite registers driving the serial load port
//
// What the load port does, at both ends
// - Words are 24 bits, sampled on rising clock
// - Strobe rise moves word into chosen latch
// - Low two bits pick reference, AB, function
// - Serial clock never faster than 20 MHz
// - Byte mode: strobe low, three bytes, then rise
// - Hold bit freezes counters, charge pump off
// - Hold bit alone never powers the device down
// - Counter reset order: func set, ref, AB, func clear
// - Power-up needs init, function, reference, AB writes
// - Monitor pin may show lock, host polls it
// - Select code 11 loads function latch, resets counters
// - Shifting continues while powered down
`timescale 1ns/10ps
`default_nettype none
module synth_loader
    import synth_pkg::*;
#(
    parameter int HALF_CYC = SCLK_HALF_CYC,  // Cycles per serial clock half
    parameter int GAP_CYC = BYTE_GAP_CYC     // Idle cycles between bytes
) (
    input wire logic clk,                // System clock
    input wire logic reset,              // Synchronous, active high
    input wire logic hsel,               // AHB slave select
    input wire logic [31:0] haddr,       // AHB address
    input wire logic [1:0] htrans,       // AHB transfer type
    input wire logic hwrite,             // AHB write
    input wire logic [2:0] hsize,        // AHB size, word only
    input wire logic [31:0] hwdata,      // AHB write data
    input wire logic hready,             // AHB bus ready
    output logic hreadyout,              // AHB slave ready
    output logic hresp,                  // AHB response, always OKAY
    output logic [31:0] hrdata,          // AHB read data
    output logic irq,                    // Level interrupt
    serial_link.host link                // Serial load port
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LOAD = 3'b001,
        ST_LOW = 3'b010,
        ST_HIGH = 3'b011,
        ST_GAP = 3'b100,
        ST_STROBE = 3'b101
    } load_e;

    typedef struct packed {
        load_e st;
        logic [7:0] div;
        logic [4:0] nbit;
        logic [1:0] step;
        logic [1:0] mode;
        logic [23:0] sh;
        logic sclk;
        logic sdo;
        logic le;
        logic [23:0] data;
        logic [23:0] refw;
        logic [23:0] abw;
        logic [23:0] funcw;
        logic byte_mode;
        logic [2:0] ists;
        logic [2:0] imsk;
        logic irq;
        logic [1:0] msync;
        logic mon;
        logic ap_wr;
        logic [7:0] ap_addr;
        logic [31:0] rdata;
    } host_s;

    host_s r, n;
    logic [2:0] ev;

    localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);
    localparam logic [7:0] GAP_LAST = 8'(GAP_CYC - 1);

    // Force the select code and, for function words, the hold bit
    function automatic logic [23:0] with_sel(input logic [23:0] w,
                                             input logic [1:0] sel);
        with_sel = {w[23:2], sel};
    endfunction

    function automatic logic [23:0] func_hold(input logic [23:0] w,
                                              input logic hold,
                                              input logic [1:0] sel);
        logic [23:0] t;
        t = with_sel(w, sel);
        t[HOLD_POS] = hold;
        func_hold = t;
    endfunction

    // Word sent at a given step of a sequence
    function automatic logic [23:0] word_for(input host_s s);
        word_for = s.data;
        if (s.mode == MODE_CRST) begin
            unique case (s.step)
                2'h0: word_for = func_hold(s.funcw, 1'b1, SEL_FUNC);
                2'h1: word_for = with_sel(s.refw, SEL_REF);
                2'h2: word_for = with_sel(s.abw, SEL_AB);
                2'h3: word_for = func_hold(s.funcw, 1'b0, SEL_FUNC);
            endcase
        end else if (s.mode == MODE_INIT) begin
            unique case (s.step)
                2'h0: word_for = func_hold(s.funcw, 1'b0, SEL_INIT);
                2'h1: word_for = func_hold(s.funcw, 1'b0, SEL_FUNC);
                2'h2: word_for = with_sel(s.refw, SEL_REF);
                2'h3: word_for = with_sel(s.abw, SEL_AB);
            endcase
        end
    endfunction

    // Register read decode
    function automatic logic [31:0] rd(input host_s s,
                                       input logic [7:0] a);
        rd = 32'h00000000;
        unique case (a)
            OFS_DATA: rd = {8'h00, s.data};
            OFS_CTRL: rd = {31'h0, s.byte_mode};
            OFS_REF: rd = {8'h00, s.refw};
            OFS_AB: rd = {8'h00, s.abw};
            OFS_FUNC: rd = {8'h00, s.funcw};
            OFS_STAT: rd = {30'h0, s.mon, s.st != ST_IDLE};
            OFS_ISTS: rd = {29'h0, s.ists};
            OFS_IMSK: rd = {29'h0, s.imsk};
            default: rd = 32'h00000000;
        endcase
    endfunction

    // Next state: bus writes, serial engine, events, then bus reads
    always_comb begin
        n = r;
        ev = 3'h0;
        n.msync = {r.msync[0], link.monitor_output};
        n.mon = r.msync[1];
        if (r.msync[1] && !r.mon) begin
            ev[EV_LOCK] = 1'b1;
        end

        // Data phase of a write; starts are ignored while busy
        if (r.ap_wr) begin
            unique case (r.ap_addr)
                OFS_DATA: begin
                    n.data = hwdata[23:0];
                    if (r.st == ST_IDLE) begin
                        n.mode = MODE_ONE;
                        n.st = ST_LOAD;
                    end
                end
                OFS_CTRL: begin
                    n.byte_mode = hwdata[CTRL_BYTE];
                    if (r.st == ST_IDLE && hwdata[CTRL_CRST]) begin
                        n.mode = MODE_CRST;
                        n.st = ST_LOAD;
                    end else if (r.st == ST_IDLE && hwdata[CTRL_INIT]) begin
                        n.mode = MODE_INIT;
                        n.st = ST_LOAD;
                    end
                end
                OFS_REF: n.refw = hwdata[23:0];
                OFS_AB: n.abw = hwdata[23:0];
                OFS_FUNC: n.funcw = hwdata[23:0];
                OFS_ISTS: n.ists = r.ists & ~hwdata[2:0];
                OFS_IMSK: n.imsk = hwdata[2:0];
                default: n.ists = r.ists;
            endcase
            // Any write while idle rewinds the step; busy writes must not
            if (r.st == ST_IDLE) begin
                n.step = 2'h0;
            end
        end

        // Serial engine; the strobe idles low between words
        unique case (r.st)
            ST_IDLE: n.le = 1'b0;
            ST_LOAD: begin
                n.sh = word_for(r);
                n.sdo = n.sh[WORD_W - 1];
                n.sclk = 1'b0;
                n.nbit = 5'h00;
                n.div = 8'h00;
                n.st = ST_LOW;
            end
            ST_LOW: begin
                n.div = r.div + 8'h01;
                if (r.div == HALF_LAST) begin
                    n.sclk = 1'b1;
                    n.div = 8'h00;
                    n.st = ST_HIGH;
                end
            end
            ST_HIGH: begin
                n.div = r.div + 8'h01;
                if (r.div == HALF_LAST) begin
                    n.sclk = 1'b0;
                    n.div = 8'h00;
                    n.nbit = r.nbit + 5'h01;
                    n.sh = {r.sh[22:0], 1'b0};
                    n.sdo = r.sh[WORD_W - 2];
                    if (r.nbit == 5'(WORD_W - 1)) begin
                        n.le = 1'b1;
                        n.st = ST_STROBE;
                    end else if (r.byte_mode
                                 && r.nbit[2:0] == 3'(BYTE_W - 1)) begin
                        n.st = ST_GAP;
                    end else begin
                        n.st = ST_LOW;
                    end
                end
            end
            ST_GAP: begin
                n.div = r.div + 8'h01;
                if (r.div == GAP_LAST) begin
                    n.div = 8'h00;
                    n.st = ST_LOW;
                end
            end
            ST_STROBE: begin
                n.div = r.div + 8'h01;
                if (r.div == HALF_LAST) begin
                    n.le = 1'b0;
                    n.div = 8'h00;
                    ev[EV_WORD] = 1'b1;
                    if (r.mode != MODE_ONE && r.step != 2'h3) begin
                        n.step = r.step + 2'h1;
                        n.st = ST_LOAD;
                    end else begin
                        ev[EV_SEQ] = r.mode != MODE_ONE;
                        n.st = ST_IDLE;
                    end
                end
            end
            default: n.st = ST_IDLE;
        endcase

        // Events win over a clear in the same cycle
        n.ists = n.ists | ev;
        n.irq = |(n.ists & n.imsk);

        // Address phase; read data is ready for the next cycle
        n.ap_wr = hsel && hready && htrans[1] && hwrite;
        n.ap_addr = {haddr[7:2], 2'b00};
        if (hsel && hready && htrans[1] && !hwrite) begin
            n.rdata = rd(n, {haddr[7:2], 2'b00});
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
            r.st <= ST_IDLE;
        end else begin
            r <= n;
        end
    end

    // Outputs; the slave never waits and never errors
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = r.rdata;
    assign irq = r.irq;
    assign link.sclk = r.sclk;
    assign link.sdata = r.sdo;
    assign link.latch_strobe = r.le;
endmodule
`default_nettype wire

/* include/synth_pkg.sv */
// Shared constants for the synthesizer serial load port and its controller
package synth_pkg;
    // Serial word and its latch selection
    localparam int WORD_W = 24;
    localparam int BYTE_W = 8;
    localparam logic [1:0] SEL_REF = 2'h0;
    localparam logic [1:0] SEL_AB = 2'h1;
    localparam logic [1:0] SEL_FUNC = 2'h2;
    localparam logic [1:0] SEL_INIT = 2'h3;

    // Function latch field positions
    localparam int HOLD_POS = 2;
    localparam int PD1_POS = 3;
    localparam int MON_LSB = 4;
    localparam int CP3_POS = 8;
    localparam logic [2:0] MON_ZERO = 3'h0;
    localparam logic [2:0] MON_LOCK = 3'h1;
    localparam logic [2:0] MON_HOLD = 3'h2;
    localparam logic [2:0] MON_ONE = 3'h3;

    // Reset values of the device latches
    localparam logic [23:0] LATCH_RST = 24'h000000;

    // Serial clock timing, derived from the system clock
    localparam longint CLK_HZ = 40000000;
    localparam longint SCLK_MAX_HZ = 20000000;
    localparam int HALF_RAW = int'((CLK_HZ + 2 * SCLK_MAX_HZ - 1)
                                   / (2 * SCLK_MAX_HZ));
    // The far end oversamples; each level must last two cycles
    localparam int HALF_MIN = 2;
    localparam int SCLK_HALF_CYC = (HALF_RAW < HALF_MIN) ? HALF_MIN
                                                         : HALF_RAW;
    localparam int BYTE_GAP_CYC = 4 * SCLK_HALF_CYC;

    // Controller register offsets (byte addresses)
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_REF = 8'h08;
    localparam logic [7:0] OFS_AB = 8'h0C;
    localparam logic [7:0] OFS_FUNC = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;
    localparam logic [7:0] OFS_ISTS = 8'h18;
    localparam logic [7:0] OFS_IMSK = 8'h1C;

    // Control and event bit positions
    localparam int CTRL_BYTE = 0;
    localparam int CTRL_CRST = 1;
    localparam int CTRL_INIT = 2;
    localparam int EV_WORD = 0;
    localparam int EV_SEQ = 1;
    localparam int EV_LOCK = 2;

    // Controller sequence kinds
    localparam logic [1:0] MODE_ONE = 2'h0;
    localparam logic [1:0] MODE_CRST = 2'h1;
    localparam logic [1:0] MODE_INIT = 2'h2;
endpackage

/* include/serial_link.sv */
// Three-wire load port plus monitor pin between controller and synthesizer
`timescale 1ns/10ps
`default_nettype none
interface serial_link;
    logic sclk;
    logic sdata;
    logic latch_strobe;
    logic monitor_output;
    modport host (output sclk, output sdata, output latch_strobe,
                  input monitor_output);
    modport dev (input sclk, input sdata, input latch_strobe,
                 output monitor_output);
endinterface
`default_nettype wire

/* hdl/synth_port.sv */
// Synthesizer end: input shift register, latches and monitor output
`timescale 1ns/10ps
`default_nettype none
module synth_port
    import synth_pkg::*;
(
    input wire logic clk,                // System clock
    input wire logic reset,              // Synchronous, active high
    serial_link.dev link,                // Serial load port
    input wire logic chip_enable,        // Enable pin, low powers down
    input wire logic lock_indication,    // Lock detect from the loop
    output logic [23:0] ref_word,        // Reference counter latch
    output logic [23:0] ab_word,         // AB counter latch
    output logic [23:0] func_word,       // Function latch
    output logic counter_reset_pulse,    // One-cycle internal reset
    output logic counters_hold,          // Counters held at load point
    output logic cp_three_state,         // Charge pump output off
    output logic power_down              // Device powered down
);
    typedef struct packed {
        logic [1:0] sclk_s;
        logic [1:0] sd_s;
        logic [1:0] le_s;
        logic [1:0] ce_s;
        logic sclk_p;
        logic le_p;
        logic [23:0] sh;
        logic [23:0] refw;
        logic [23:0] abw;
        logic [23:0] funcw;
        logic ab_armed;
        logic pulse;
        logic mon;
    } dev_s;

    dev_s r, n;
    logic hold_now;

    // Hold comes from the function bit or the reset pulse, never from PD
    assign hold_now = r.funcw[HOLD_POS] | r.pulse;

    // Next state of the whole end
    always_comb begin
        n = r;
        n.sclk_s = {r.sclk_s[0], link.sclk};
        n.sd_s = {r.sd_s[0], link.sdata};
        n.le_s = {r.le_s[0], link.latch_strobe};
        n.ce_s = {r.ce_s[0], chip_enable};
        n.sclk_p = r.sclk_s[1];
        n.le_p = r.le_s[1];
        n.pulse = 1'b0;
        // Shifting goes on whatever the power state
        if (r.sclk_s[1] && !r.sclk_p) begin
            n.sh = {r.sh[22:0], r.sd_s[1]};
        end
        if (r.le_s[1] && !r.le_p) begin
            unique case (r.sh[1:0])
                SEL_REF: n.refw = r.sh;
                SEL_AB: begin
                    n.abw = r.sh;
                    // First AB load after an init also resets counters
                    n.pulse = r.ab_armed;
                    n.ab_armed = 1'b0;
                end
                SEL_FUNC: n.funcw = r.sh;
                SEL_INIT: begin
                    n.funcw = r.sh;
                    n.pulse = 1'b1;
                    n.ab_armed = 1'b1;
                end
            endcase
        end
        // Monitor pin selection, lock detect among the sources
        unique case (r.funcw[MON_LSB +: 3])
            MON_LOCK: n.mon = lock_indication;
            MON_HOLD: n.mon = hold_now;
            MON_ONE: n.mon = 1'b1;
            default: n.mon = 1'b0;
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
            r.refw <= LATCH_RST;
            r.abw <= LATCH_RST;
            r.funcw <= LATCH_RST;
        end else begin
            r <= n;
        end
    end

    // Outputs
    assign link.monitor_output = r.mon;
    assign ref_word = r.refw;
    assign ab_word = r.abw;
    assign func_word = r.funcw;
    assign counter_reset_pulse = r.pulse;
    assign power_down = ~r.ce_s[1] | r.funcw[PD1_POS];
    assign counters_hold = hold_now | power_down;
    assign cp_three_state = counters_hold | r.funcw[CP3_POS];
endmodule
`default_nettype wire

/* testbench/synth_link_chk.sv */
// Checker for the serial load port wires between the two ends
`timescale 1ns/10ps
`default_nettype none
module synth_link_chk (
    input wire logic clk,            // System clock
    input wire logic reset,          // Synchronous, active high
    input wire logic sclk,           // Serial clock
    input wire logic sdata,          // Serial data
    input wire logic latch_strobe,   // Latch strobe
    input wire logic monitor_output  // Monitor pin
);
    logic sclk_q;
    logic [5:0] rises;
    logic rise;

    // Rising serial clock edges seen by the system clock
    assign rise = sclk & ~sclk_q;

    // Bits shifted since the last strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            sclk_q <= 1'b0;
            rises <= 6'h00;
        end else begin
            sclk_q <= sclk;
            if (latch_strobe)
                rises <= 6'h00;
            else if (rise)
                rises <= rises + 6'h01;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sclk_low_min_a: assert property ($rose(sclk) |-> !$past(sclk, 2))
        else $error("serial clock low phase too short");
    sclk_high_min_a: assert property ($fell(sclk) |-> $past(sclk, 2))
        else $error("serial clock high phase too short");
    data_hold_high_a: assert property (sclk && $past(sclk) |-> $stable(sdata))
        else $error("serial data moved while clock high");
    strobe_clock_low_a: assert property (latch_strobe |-> !sclk)
        else $error("strobe high while serial clock high");
    word_bits_a: assert property ($rose(latch_strobe) |-> rises == 6'd24)
        else $error("strobe after a word that is not 24 bits");
    bit_spacing_a: assert property (rise && rises < 6'd23 |-> ##[4:30] rise)
        else $error("word stalled between bits");
    strobe_after_a: assert property (rise && rises == 6'd23
        |-> ##[2:30] $rose(latch_strobe)) else $error("no strobe after bit 24");
    // Default half period of two cycles is assumed here
    strobe_width_a: assert property ($rose(latch_strobe)
        |-> latch_strobe [*2] ##1 !latch_strobe) else $error("strobe width");

    word_done_c: cover property ($rose(latch_strobe));
    byte_gap_c: cover property ((rises == 6'd8 && !sclk) [*8]);
    monitor_rise_c: cover property ($rose(monitor_output));
endmodule
`default_nettype wire

/* testbench/test_pll_synth_serial_load_port.sv */
// Bench joining controller and synthesizer ends over the serial link
`timescale 1ns/10ps
`default_nettype none
module test_pll_synth_serial_load_port
    import synth_pkg::*;
();
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic chip_enable = 1'b1;
    logic lock_indication = 1'b0;
    logic hreadyout, hresp, irq, counter_reset_pulse;
    logic counters_hold, cp_three_state, power_down;
    logic [31:0] hrdata, rd;
    logic [23:0] ref_word, ab_word, func_word, cap = 24'h0, cap_word;
    logic sclk_q = 1'b0, stb_q = 1'b0, long_q = 1'b0, gap_long = 1'b0;
    logic [7:0] seq_sel = 8'h00;
    logic [3:0] seq_hold = 4'h0;
    int errors = 0, checks_done = 0, nbits = 0, cap_bits = 0, low_run = 0;
    int hold_n = 0, pd_n = 0, cpx_n = 0, pulse_n = 0, h0, p0, q0, n;
    logic [23:0] w;
    logic e;

    serial_link link();
    synth_loader i_synth_loader (.clk(clk), .reset(reset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .irq(irq), .link(link.host));
    synth_port i_synth_port (.clk(clk), .reset(reset), .link(link.dev),
        .chip_enable(chip_enable), .lock_indication(lock_indication),
        .ref_word(ref_word), .ab_word(ab_word), .func_word(func_word),
        .counter_reset_pulse(counter_reset_pulse),
        .counters_hold(counters_hold), .cp_three_state(cp_three_state),
        .power_down(power_down));
    synth_link_chk i_synth_link_chk (.clk(clk), .reset(reset),
        .sclk(link.sclk), .sdata(link.sdata),
        .latch_strobe(link.latch_strobe),
        .monitor_output(link.monitor_output));

    always #12.5 clk = ~clk;

    // Wire watcher: rebuilds each word and tallies device states
    always @(posedge clk) begin
        sclk_q <= link.sclk;
        stb_q <= link.latch_strobe;
        low_run <= link.sclk ? 0 : low_run + 1;
        if (link.sclk && !sclk_q) begin
            cap <= {cap[22:0], link.sdata};
            nbits <= nbits + 1;
            if (nbits > 0 && low_run >= BYTE_GAP_CYC)
                long_q <= 1'b1;
        end else if (link.latch_strobe && !stb_q) begin
            cap_word <= cap;
            cap_bits <= nbits;
            gap_long <= long_q;
            long_q <= 1'b0;
            nbits <= 0;
            seq_sel <= {seq_sel[5:0], cap[1:0]};
            seq_hold <= {seq_hold[2:0], cap[HOLD_POS]};
        end
        hold_n <= hold_n + int'(counters_hold === 1'b1);
        pd_n <= pd_n + int'(power_down === 1'b1);
        cpx_n <= cpx_n + int'(counters_hold === 1'b1 && !cp_three_state);
        pulse_n <= pulse_n + int'(counter_reset_pulse === 1'b1);
    end

    task conclude;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task tmo;
        errors++;
        $display("Error wait expected done seen timeout");
        conclude();
    endtask

    // Bounded wait for hready at a rising edge
    task rdy;
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 40);
        if (k >= 40)
            tmo();
    endtask

    // One single AHB-Lite transfer, address phase then data phase
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        rdy();
        rd = hrdata;
    endtask

    task rc(input string what, input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask

    // Poll the event register until the given bit is set
    task wait_ev(input int b);
        int k;
        k = 0;
        do begin
            ahb(1'b0, OFS_ISTS, 32'h0);
            k++;
        end while (rd[b] !== 1'b1 && k < 500);
        if (k >= 500)
            tmo();
    endtask

    // Latches settle three cycles after the strobe
    task send(input logic [23:0] v);
        ahb(1'b1, OFS_DATA, {8'h0, v});
        wait_ev(EV_WORD);
        ahb(1'b1, OFS_ISTS, 32'h1);
        repeat (6) @(posedge clk);
        chk("wire word", {8'h0, v}, {8'h0, cap_word});
        chk("wire bits", 32'd24, cap_bits);
        chk("idle wires", 32'h0, {30'h0, link.sclk, link.latch_strobe});
    endtask

    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        rc("stat", OFS_STAT, 32'h0);
        rc("ists", OFS_ISTS, 32'h0);
        rc("imsk", OFS_IMSK, 32'h0);
        chk("hresp", 32'h0, {31'h0, hresp});
        chk("latches", 32'h0, {8'h0, ref_word | ab_word | func_word});
        ahb(1'b1, 8'h40, 32'hFFFFFFFF);
        rc("unmapped", 8'h40, 32'h0);
        // Reference, AB and function codes land in their own latches, word mode has no gap
        for (int s = 0; s < 3; s++) begin
            w = 24'h5A3C30 | 24'(s);
            send(w);
            chk("latch", {8'h0, w}, {8'h0, s == 0 ? ref_word :
                s == 1 ? ab_word : func_word});
            chk("gap", 32'h0, {31'h0, gap_long});
        end
        ahb(1'b1, OFS_CTRL, 32'h1);
        send(24'h0F0F01);
        chk("byte ab", 32'h0F0F01, {8'h0, ab_word});
        chk("byte gap", 32'h1, {31'h0, gap_long});
        ahb(1'b1, OFS_CTRL, 32'h0);
        chip_enable <= 1'b0;
        send(24'h123450);
        chk("pd ref", 32'h123450, {8'h0, ref_word});
        chk("pd", 32'h1, {31'h0, power_down});
        chip_enable <= 1'b1;
        // Interrupt raised, cleared, then masked
        ahb(1'b1, OFS_IMSK, 32'h1);
        ahb(1'b1, OFS_DATA, 32'h000021);
        n = 0;
        while (irq !== 1'b1 && n < 600) begin
            @(posedge clk);
            n++;
        end
        if (n >= 600)
            tmo();
        chk("irq set", 32'h1, {31'h0, irq});
        ahb(1'b1, OFS_ISTS, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq clear", 32'h0, {31'h0, irq});
        ahb(1'b1, OFS_IMSK, 32'h0);
        ahb(1'b1, OFS_DATA, 32'h000021);
        wait_ev(EV_WORD);
        chk("irq masked", 32'h0, {31'h0, irq});
        ahb(1'b1, OFS_ISTS, 32'h7);
        rc("ists w1c", OFS_ISTS, 32'h0);
        // Counter reset sequence
        ahb(1'b1, OFS_REF, 32'h00ABC3);
        ahb(1'b1, OFS_AB, 32'h012343);
        ahb(1'b1, OFS_FUNC, 32'h000080);
        h0 = hold_n;
        p0 = pd_n;
        q0 = pulse_n;
        ahb(1'b1, OFS_CTRL, 32'h2);
        // A one-word start while busy must leave the sequence alone
        ahb(1'b1, OFS_DATA, 32'h000021);
        wait_ev(EV_SEQ);
        repeat (6) @(posedge clk);
        chk("crst order", 32'h86, {24'h0, seq_sel});
        chk("crst hold", 32'h8, {28'h0, seq_hold});
        chk("crst ref", 32'h00ABC0, {8'h0, ref_word});
        chk("crst ab", 32'h012341, {8'h0, ab_word});
        chk("crst func", 32'h000082, {8'h0, func_word});
        chk("held", 32'h1, {31'h0, hold_n > h0});
        chk("cp off", 32'h0, cpx_n);
        chk("no pd", p0, pd_n);
        chk("released", 32'h0, {31'h0, counters_hold});
        ahb(1'b1, OFS_ISTS, 32'h7);
        // Init sequence pulses the counter reset twice
        q0 = pulse_n;
        ahb(1'b1, OFS_CTRL, 32'h4);
        wait_ev(EV_SEQ);
        repeat (6) @(posedge clk);
        chk("init order", 32'hE1, {24'h0, seq_sel});
        chk("init hold", 32'h0, {28'h0, seq_hold});
        chk("pulses", 32'd2, pulse_n - q0);
        chk("init func", 32'h000082, {8'h0, func_word});
        ahb(1'b1, OFS_ISTS, 32'h7);
        // Monitor select codes with lock present
        lock_indication <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            e = (m == 1 || m == 3);
            send({17'h0, 3'(m), 4'h2});
            chk("monitor", {31'h0, e}, {31'h0, link.monitor_output});
            ahb(1'b0, OFS_STAT, 32'h0);
            chk("stat mon", {31'h0, e}, {31'h0, rd[1]});
        end
        ahb(1'b0, OFS_ISTS, 32'h0);
        chk("mon event", 32'h1, {31'h0, rd[EV_LOCK]});
        conclude();
    end
endmodule
`default_nettype wire
